/* src/bsi_cfg.svh */
// Constants for the boundary-scan test logic.
`ifndef BSI_CFG_SVH
`define BSI_CFG_SVH
`define BSI_IR_W        4
`define BSI_IR_CAPTURE  4'h1
`define BSI_I_EXTEST    4'h0
`define BSI_I_SAMPLE    4'h3
`define BSI_I_CLAMP     4'h5
`define BSI_I_HIGHZ     4'h7
`define BSI_I_CLAMP_OFF 4'h9
`define BSI_I_INTEST    4'hc
`define BSI_I_IDCODE    4'he
`define BSI_I_BYPASS    4'hf
`define BSI_ID_W        32
`define BSI_BYPASS_CAP  1'b0
`endif

/* src/bsi_pkg.sv */
// Types for the boundary-scan test logic.
package bsi_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bsi_state_t;
endpackage

/* src/bsi_tap.sv */
// Test access port with instruction, bypass, identity and boundary chain registers.
`timescale 1ns/100ps
`include "bsi_cfg.svh"
module bsi_tap #(
  parameter int                 NIN   = 4,
  parameter int                 NOUT  = 4,
  parameter logic [31:0]        IDVAL = 32'h1234_5677 // Arbitrary identity value.
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             trst_n,
  output logic                  tdo,
  output logic                  tdo_oe,
  input  wire logic [NIN-1:0]   pad_in,
  output logic [NIN-1:0]        core_in,
  input  wire logic [NOUT-1:0]  core_out,
  input  wire logic [NOUT-1:0]  core_oe,
  output logic [NOUT-1:0]       pad_out,
  output logic [NOUT-1:0]       pad_oe
);
  // Chain: inputs, outputs, then one enable cell per output (closest to serial out first).
  localparam int N = NIN + 2 * NOUT;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the pins; only the second stage is read.
  logic [3:0] s1;
  logic [3:0] s2;
  logic [NIN-1:0] pi1;
  logic [NIN-1:0] pi2;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      pi1 <= '0;
      pi2 <= '0;
    end
    else if (ce)
    begin
      s1 <= {tck, tms, tdi, trst_n};
      s2 <= s1;
      pi1 <= pad_in;
      pi2 <= pi1;
    end
  end
  wire logic tck_s = s2[3];
  wire logic tms_s = s2[2];
  wire logic tdi_s = s2[1];
  wire logic trst_s = s2[0];

  // Edge finder on the synchronised test clock.
  logic tck_d;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tck_d <= 1'b0;
    else if (ce)
      tck_d <= tck_s;
  end
  wire logic rise = ce && tck_s && !tck_d;
  wire logic fall = ce && !tck_s && tck_d;
  wire logic treset = !rst_n || !trst_s;

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine.
  bsi_pkg::bsi_state_t st;
  bsi_pkg::bsi_state_t next_st;
  always_comb
  begin
    next_st = st;
    unique case (st)
      bsi_pkg::TLR:    next_st = tms_s ? bsi_pkg::TLR    : bsi_pkg::RTI;
      bsi_pkg::RTI:    next_st = tms_s ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
      bsi_pkg::SEL_DR: next_st = tms_s ? bsi_pkg::SEL_IR : bsi_pkg::CAP_DR;
      bsi_pkg::CAP_DR: next_st = tms_s ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
      bsi_pkg::SH_DR:  next_st = tms_s ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
      bsi_pkg::EX1_DR: next_st = tms_s ? bsi_pkg::UPD_DR : bsi_pkg::PA_DR;
      bsi_pkg::PA_DR:  next_st = tms_s ? bsi_pkg::EX2_DR : bsi_pkg::PA_DR;
      bsi_pkg::EX2_DR: next_st = tms_s ? bsi_pkg::UPD_DR : bsi_pkg::SH_DR;
      bsi_pkg::UPD_DR: next_st = tms_s ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
      bsi_pkg::SEL_IR: next_st = tms_s ? bsi_pkg::TLR    : bsi_pkg::CAP_IR;
      bsi_pkg::CAP_IR: next_st = tms_s ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
      bsi_pkg::SH_IR:  next_st = tms_s ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
      bsi_pkg::EX1_IR: next_st = tms_s ? bsi_pkg::UPD_IR : bsi_pkg::PA_IR;
      bsi_pkg::PA_IR:  next_st = tms_s ? bsi_pkg::EX2_IR : bsi_pkg::PA_IR;
      bsi_pkg::EX2_IR: next_st = tms_s ? bsi_pkg::UPD_IR : bsi_pkg::SH_IR;
      bsi_pkg::UPD_IR: next_st = tms_s ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (treset)
      st <= bsi_pkg::TLR;
    else if (rise)
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register: shift stage and current instruction.
  logic [`BSI_IR_W-1:0] ir_sh;
  logic [`BSI_IR_W-1:0] ir;
  always_ff @(posedge mclk)
  begin
    if (treset || (rise && st == bsi_pkg::TLR))
    begin
      ir_sh <= `BSI_IR_CAPTURE;
      ir <= `BSI_I_IDCODE;
    end
    else if (rise)
    begin
      if (st == bsi_pkg::CAP_IR)
        ir_sh <= `BSI_IR_CAPTURE;
      else if (st == bsi_pkg::SH_IR)
        ir_sh <= {tdi_s, ir_sh[`BSI_IR_W-1:1]};
      if (st == bsi_pkg::UPD_IR)
        ir <= ir_sh;
    end
  end

  // Decodes of the current instruction; unknown codes fall back to bypass.
  wire logic sel_chain = (ir == `BSI_I_SAMPLE) || (ir == `BSI_I_EXTEST)
                      || (ir == `BSI_I_INTEST);
  wire logic sel_id = (ir == `BSI_I_IDCODE);
  wire logic sel_byp = !sel_chain && !sel_id;
  wire logic test_md = (ir == `BSI_I_EXTEST) || (ir == `BSI_I_INTEST);
  wire logic in_test = (ir == `BSI_I_INTEST);
  wire logic clamp_drivers_off_instr = (ir == `BSI_I_CLAMP_OFF);
  wire logic clamp_md = (ir == `BSI_I_CLAMP) || clamp_drivers_off_instr;
  wire logic hiz_md = (ir == `BSI_I_HIGHZ);

  ////////////////////////////////////////////////////////////////////////////
  // Bypass and identity registers; neither reacts to update-data.
  logic byp;
  logic [`BSI_ID_W-1:0] id_sh;
  always_ff @(posedge mclk)
  begin
    if (treset)
    begin
      byp <= `BSI_BYPASS_CAP;
      id_sh <= IDVAL;
    end
    else if (rise)
    begin
      if (sel_byp && st == bsi_pkg::CAP_DR)
        byp <= `BSI_BYPASS_CAP;
      else if (sel_byp && st == bsi_pkg::SH_DR)
        byp <= tdi_s;
      if (sel_id && st == bsi_pkg::CAP_DR)
        id_sh <= IDVAL;
      else if (sel_id && st == bsi_pkg::SH_DR)
        id_sh <= {tdi_s, id_sh[`BSI_ID_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary chain shift stage and update latch; no reset, contents are
  // undefined after test reset, which saves a reset tree on a long chain.
  logic [N-1:0] pin_boundary_chain;
  logic [N-1:0] chain_latch;
  logic [N-1:0] cap;
  genvar g;
  generate
    for (g = 0; g < NIN; g++)
    begin : g_in
      // Input cells capture the core side inverted under internal test.
      assign cap[g] = in_test ? ~core_in[g] : pi2[g];
    end
    for (g = 0; g < NOUT; g++)
    begin : g_out
      // Output data and enable cells capture what reaches the pad, or the core side under internal test.
      assign cap[NIN+g] = in_test ? core_out[g] : pad_out[g];
      assign cap[NIN+NOUT+g] = in_test ? core_oe[g] : pad_oe[g];
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rise && sel_chain)
    begin
      if (st == bsi_pkg::CAP_DR)
        pin_boundary_chain <= cap;
      else if (st == bsi_pkg::SH_DR)
        pin_boundary_chain <= {tdi_s, pin_boundary_chain[N-1:1]};
      if (st == bsi_pkg::UPD_DR)
        chain_latch <= pin_boundary_chain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and core muxing, registered so outputs come from flip-flops.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      core_in <= '0;
      pad_out <= '0;
      pad_oe <= '0;
    end
    else if (ce)
    begin
      core_in <= test_md ? chain_latch[NIN-1:0] : pi2;
      pad_out <= (test_md || clamp_md) ? chain_latch[NIN+NOUT-1:NIN] : core_out;
      if (clamp_drivers_off_instr || hiz_md)
        pad_oe <= '0;
      else if (test_md || ir == `BSI_I_CLAMP)
        pad_oe <= chain_latch[N-1:NIN+NOUT];
      else
        pad_oe <= core_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output changes on the falling test clock edge.
  always_ff @(posedge mclk)
  begin
    if (treset)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (fall)
    begin
      tdo_oe <= (st == bsi_pkg::SH_DR) || (st == bsi_pkg::SH_IR);
      if (st == bsi_pkg::SH_IR)
        tdo <= ir_sh[0];
      else if (sel_chain)
        tdo <= pin_boundary_chain[0];
      else if (sel_id)
        tdo <= id_sh[0];
      else
        tdo <= byp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_irdef;
    @(posedge mclk) disable iff (!rst_n)
    $rose(!trst_s) |=> ir == `BSI_I_IDCODE && st == bsi_pkg::TLR;
  endproperty
  a_irdef: assert property (p_irdef) else $error("reset did not select identity");
  property p_capir;
    @(posedge mclk) disable iff (treset)
    rise && st == bsi_pkg::CAP_IR |=> ir_sh == `BSI_IR_CAPTURE;
  endproperty
  a_capir: assert property (p_capir) else $error("ir capture wrong");
  property p_bcap;
    @(posedge mclk) disable iff (treset)
    rise && sel_byp && st == bsi_pkg::CAP_DR |=> !byp;
  endproperty
  a_bcap: assert property (p_bcap) else $error("bypass capture not zero");
  property p_bupd;
    @(posedge mclk) disable iff (treset)
    rise && st == bsi_pkg::UPD_DR |=> $stable(byp) && $stable(id_sh);
  endproperty
  a_bupd: assert property (p_bupd) else $error("update changed bypass or id");
  property p_bsh;
    @(posedge mclk) disable iff (treset)
    rise && sel_byp && st == bsi_pkg::SH_DR |=> byp == $past(tdi_s);
  endproperty
  a_bsh: assert property (p_bsh) else $error("bypass shift wrong");
  property p_idcap;
    @(posedge mclk) disable iff (treset)
    rise && sel_id && st == bsi_pkg::CAP_DR |=> id_sh == IDVAL;
  endproperty
  a_idcap: assert property (p_idcap) else $error("id capture wrong");
  property p_clz;
    @(posedge mclk) disable iff (!rst_n)
    ce && clamp_drivers_off_instr ##1 ce |-> pad_oe == '0;
  endproperty
  a_clz: assert property (p_clz) else $error("driver on under clamp");
  property p_sys;
    @(posedge mclk) disable iff (!rst_n)
    ce && !test_md |=> core_in == $past(pi2);
  endproperty
  a_sys: assert property (p_sys) else $error("system mode not straight");
  property p_tst;
    @(posedge mclk) disable iff (!rst_n)
    ce && test_md |=> core_in == $past(chain_latch[NIN-1:0]);
  endproperty
  a_tst: assert property (p_tst) else $error("test mode not from latch");
  property p_tdo;
    @(posedge mclk) disable iff (treset)
    !fall |=> $stable(tdo);
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved off falling edge");
  c_id: cover property (@(posedge mclk) rise && sel_id && st == bsi_pkg::SH_DR);
  c_int: cover property (@(posedge mclk) rise && in_test && st == bsi_pkg::UPD_DR);
  c_clz: cover property (@(posedge mclk) rise && clamp_drivers_off_instr && st == bsi_pkg::SH_DR);
endmodule

/* sim/bsi_tester.sv */
// Tester model that drives the test access port pins from the board side.
`timescale 1ns/100ps
module bsi_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  // The test clock stands low between frames, as a real tester leaves it.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
  end

  // One test clock of 160 ns: pins change at the fall and are taken at the rise.
  // The serial output is read late in the high phase, long after the last fall.
  task automatic clk(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    #80 q = tdo;
    tck = 1'b0;
  endtask

  // Pulse the test reset with the mode line high, then step to run-test/idle.
  task automatic treset();
    logic q;
    tms = 1'b1;
    trst_n = 1'b0;
    #200 trst_n = 1'b1;
    #100 clk(1'b0, 1'b1, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scan n bits, LSB first, from and back to run-test/idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    clk(1'b1, 1'b1, q);
    if (ir)
      clk(1'b1, 1'b1, q);
    clk(1'b0, 1'b1, q);
    clk(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      clk(i == n - 1, din[i], q);
      dout[i] = q;
    end
    // The tester drives the input line high, so it idles high after the frame.
    clk(1'b1, 1'b1, q);
    clk(1'b0, 1'b1, q);
  endtask
endmodule

/* sim/bsi_tap_tb.sv */
// Self-checking bench for the boundary-scan test logic.
`timescale 1ns/100ps
module bsi_tap_tb;
  localparam int          NIN  = 4;
  localparam int          NOUT = 4;
  localparam logic [31:0] ID   = 32'h0c3a_5e91; // Arbitrary identity value.
  localparam logic [11:0] PRE  = 12'h3c6;
  localparam logic [11:0] VEC  = 12'h5a3;
  logic            mclk;
  logic            rst_n;
  logic            tck;
  logic            tms;
  logic            tdi;
  logic            trst_n;
  logic            tdo;
  logic            tdo_oe;
  logic [NIN-1:0]  pad_in;
  logic [NIN-1:0]  core_in;
  logic [NOUT-1:0] core_out;
  logic [NOUT-1:0] core_oe;
  logic [NOUT-1:0] pad_out;
  logic [NOUT-1:0] pad_oe;
  logic [31:0]     r;
  int              n_fail = 0;
  int              checks_done = 0;
  int              cyc = 0;

  bsi_tap #(.NIN(NIN), .NOUT(NOUT), .IDVAL(ID)) DUT (.mclk(mclk), .rst_n(rst_n),
    .ce(1'b1), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .pad_in(pad_in), .core_in(core_in), .core_out(core_out),
    .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe));
  bsi_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

  // The clock, and a ceiling on run length so that a hang still gets a verdict.
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      $display("Error timeout expected done seen hang");
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Pads and core must see each other straight through.
  task automatic sys();
    chk("pad_out", 32'(pad_out), 32'(core_out));
    chk("pad_oe", 32'(pad_oe), 32'(core_oe));
    chk("core_in", 32'(core_in), 32'(pad_in));
    chk("tdo_oe", 32'(tdo_oe), 32'h0);
  endtask

  // A twelve-bit pass through the one-bit path comes back one place late.
  task automatic byp();
    tester.scan(1'b0, 12, 32'hb6d, r);
    chk("bypass", r, 32'h6da);
  endtask

  task automatic t_id();
    tester.scan(1'b0, 32, 32'h0, r);
    chk("idcode", r, ID);
    sys();
  endtask

  task automatic t_byp();
    tester.scan(1'b1, 4, 32'hf, r);
    chk("ir_capture", r, 32'h1);
    byp();
    byp();
    sys();
  endtask

  // Preload a guard pattern, then clamp with the drivers switched off.
  task automatic t_clamp_off();
    tester.scan(1'b1, 4, 32'h3, r);
    tester.scan(1'b0, 12, 32'(PRE), r);
    sys();
    tester.scan(1'b1, 4, 32'h9, r);
    chk("clamp_off_oe", 32'(pad_oe), 32'h0);
    chk("clamp_off_out", 32'(pad_out), 32'(PRE[7:4]));
    byp();
    // The plain clamp drives data and enables from the same stored pattern.
    tester.scan(1'b1, 4, 32'h5, r);
    chk("clamp_out", 32'(pad_out), 32'(PRE[7:4]));
    chk("clamp_oe", 32'(pad_oe), 32'(PRE[11:8]));
  endtask

  // Internal test: latched values rule, capture inverts the input cells.
  task automatic t_intest();
    tester.scan(1'b1, 4, 32'h0, r);
    chk("extest_in", 32'(core_in), 32'(PRE[3:0]));
    chk("extest_oe", 32'(pad_oe), 32'(PRE[11:8]));
    tester.scan(1'b1, 4, 32'hc, r);
    chk("intest_in", 32'(core_in), 32'(PRE[3:0]));
    chk("intest_out", 32'(pad_out), 32'(PRE[7:4]));
    chk("intest_oe", 32'(pad_oe), 32'(PRE[11:8]));
    tester.scan(1'b0, 12, 32'(VEC), r);
    chk("intest_cap", r, 32'ha59);
    chk("step_in", 32'(core_in), 32'(VEC[3:0]));
    chk("step_out", 32'(pad_out), 32'(VEC[7:4]));
    chk("step_oe", 32'(pad_oe), 32'(VEC[11:8]));
  endtask

  initial
  begin
    rst_n = 1'b0;
    pad_in = 4'h9;
    core_out = 4'h5;
    core_oe = 4'ha;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge mclk);
    // All tester delays are whole clock periods, so this offset keeps every
    // pin change clear of the sampling edge.
    #1 tester.treset();
    t_id();
    t_byp();
    t_clamp_off();
    t_intest();
    tester.treset();
    t_id();
    stop_test();
  end
endmodule
